//--- design/erc_pkg.sv
`default_nettype none

package erc_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] IDX_LCV_HIGH   = 6'h16;
  localparam logic [5:0] IDX_LCV_LOW    = 6'h17;
  localparam logic [5:0] IDX_CRC_HIGH   = 6'h18;
  localparam logic [5:0] IDX_CRC_LOW    = 6'h19;
  localparam logic [5:0] IDX_IRQ_ZERO   = 6'h1B;
  localparam logic [5:0] IDX_IRQ_ONE    = 6'h1C;
  localparam logic [5:0] IDX_CONTROL    = 6'h20;
  localparam logic [5:0] IDX_MASK_ZERO  = 6'h21;
  localparam logic [5:0] IDX_MASK_ONE   = 6'h22;
  localparam logic [5:0] IDX_OVFL       = 6'h23;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTL_EXZ_BIT      = 0;
  localparam int CTL_OVFL_EN_BIT  = 1;
  localparam int OVFL_LCV_BIT     = 3;

  localparam int W0_FRAME_SYNC    = 7;
  localparam int W0_MF_SYNC       = 6;
  localparam int W0_CRC_SYNC      = 5;
  localparam int W0_ALL_ONES      = 4;
  localparam int W0_SIG_LOSS      = 3;
  localparam int W0_DOUBLE_FAS    = 2;
  localparam int W0_MF_LOSS       = 1;
  localparam int W0_SLIP          = 0;

  localparam int W1_FAS_BIT       = 7;
  localparam int W1_LOCAL_CRC     = 6;
  localparam int W1_FAR_EBIT      = 5;
  localparam int W1_SLOT16        = 4;
  localparam int W1_BIPOLAR       = 3;
  localparam int W1_PATTERN       = 2;
  localparam int W1_ALTERNATING   = 1;
  localparam int W1_REMOTE        = 0;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  localparam logic [7:0]  LOW_ROLL     = 8'hFF;
  localparam logic [9:0]  AUX_RUN_BITS = 10'h200;

endpackage

`default_nettype wire

//--- design/erc_rx_monitor.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module erc_rx_monitor (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bipolar_violation,
  input  wire logic        excess_zero_seen,
  input  wire logic        crc_error,
  input  wire logic        frame_sync,
  input  wire logic        multiframe_sync,
  input  wire logic        crc_sync,
  input  wire logic        all_ones,
  input  wire logic        signal_loss,
  input  wire logic        double_errored_fas,
  input  wire logic        multiframe_loss,
  input  wire logic        receive_slip,
  input  wire logic        fas_bit_error,
  input  wire logic        far_end_error_bit,
  input  wire logic        slot16_all_ones,
  input  wire logic        test_pattern_error,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_valid,
  input  wire logic        nfas_valid,
  input  wire logic        nfas_bit3,
  output logic             lcv_overflow_pending
);

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic idx_mapped(input logic [5:0] idx);
    case (idx)
      erc_pkg::IDX_LCV_HIGH,
      erc_pkg::IDX_LCV_LOW,
      erc_pkg::IDX_CRC_HIGH,
      erc_pkg::IDX_CRC_LOW,
      erc_pkg::IDX_IRQ_ZERO,
      erc_pkg::IDX_IRQ_ONE,
      erc_pkg::IDX_CONTROL,
      erc_pkg::IDX_MASK_ZERO,
      erc_pkg::IDX_MASK_ONE,
      erc_pkg::IDX_OVFL:
        idx_mapped = 1'b1;
      default:
        idx_mapped = 1'b0;
    endcase
  endfunction

  logic [5:0]  idx;
  logic        hit;
  logic        done;
  logic        rd_done;
  logic        wr_done;
  logic        rd_irq_zero;
  logic        rd_irq_one;
  logic        rd_ovfl;

  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  logic [7:0]  control_q;
  logic [7:0]  mask_zero_q;
  logic [7:0]  mask_one_q;
  logic [15:0] lcv_count_q;
  logic [15:0] crc_count_q;
  logic [7:0]  irq_zero_q;
  logic [7:0]  irq_one_q;
  logic [7:0]  ovfl_q;
  logic [7:0]  ev_zero;
  logic [7:0]  ev_one;
  logic        lcv_event;
  logic        lcv_roll;

  logic        frame_sync_q;
  logic        multiframe_sync_q;
  logic        crc_sync_q;
  logic        all_ones_q;
  logic        prev_bit_q;
  logic [9:0]  alt_run_q;
  logic        alt_hit;

  assign idx         = paddr[7:2];
  assign hit         = idx_mapped(idx) && (paddr[1:0] == 2'b00);
  assign done        = psel && penable && pready_q;
  assign rd_done     = done && !pwrite && hit;
  assign wr_done     = done && pwrite && hit;
  assign rd_irq_zero = rd_done && (idx == erc_pkg::IDX_IRQ_ZERO);
  assign rd_irq_one  = rd_done && (idx == erc_pkg::IDX_IRQ_ONE);
  assign rd_ovfl     = rd_done && (idx == erc_pkg::IDX_OVFL);

  // ************************************************************
  // APB slave: one wait state, then data and ready from flops
  // ************************************************************
  // Writes to counters and status words are dropped with no error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit;
      prdata_q  <= (psel && penable && !pready_q && !pwrite) ?
                   prdata_d : 32'h0000_0000;
    end
  end

  always_comb
  begin
    prdata_d = 32'h0000_0000;
    case (idx)
      erc_pkg::IDX_LCV_HIGH:  prdata_d[7:0] = lcv_count_q[15:8];
      erc_pkg::IDX_LCV_LOW:   prdata_d[7:0] = lcv_count_q[7:0];
      erc_pkg::IDX_CRC_HIGH:  prdata_d[7:0] = crc_count_q[15:8];
      erc_pkg::IDX_CRC_LOW:   prdata_d[7:0] = crc_count_q[7:0];
      erc_pkg::IDX_IRQ_ZERO:  prdata_d[7:0] = irq_zero_q;
      erc_pkg::IDX_IRQ_ONE:   prdata_d[7:0] = irq_one_q;
      erc_pkg::IDX_CONTROL:   prdata_d[7:0] = control_q;
      erc_pkg::IDX_MASK_ZERO: prdata_d[7:0] = mask_zero_q;
      erc_pkg::IDX_MASK_ONE:  prdata_d[7:0] = mask_one_q;
      erc_pkg::IDX_OVFL:      prdata_d[7:0] = ovfl_q;
      default:                prdata_d      = 32'h0000_0000;
    endcase
    if (!(paddr[1:0] == 2'b00))
    begin
      prdata_d = 32'h0000_0000;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ************************************************************
  // Software control and mask registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_q <= erc_pkg::RST_BYTE;
    end
    else if (wr_done && (idx == erc_pkg::IDX_CONTROL))
    begin
      control_q <= pwdata[7:0];
    end
  end

  // Mask bit high lets its event through; reset masks every event
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_zero_q <= erc_pkg::RST_BYTE;
    end
    else if (wr_done && (idx == erc_pkg::IDX_MASK_ZERO))
    begin
      mask_zero_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_one_q <= erc_pkg::RST_BYTE;
    end
    else if (wr_done && (idx == erc_pkg::IDX_MASK_ONE))
    begin
      mask_one_q <= pwdata[7:0];
    end
  end

  // ************************************************************
  // Error counters
  // ************************************************************
  // No snapshot: a count landing between the two byte reads tears
  assign lcv_event = bipolar_violation ||
                     (control_q[erc_pkg::CTL_EXZ_BIT] &&
                      excess_zero_seen);
  assign lcv_roll  = lcv_event &&
                     (lcv_count_q[7:0] == erc_pkg::LOW_ROLL);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lcv_count_q <= erc_pkg::RST_COUNT;
    end
    else if (lcv_event)
    begin
      lcv_count_q <= lcv_count_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crc_count_q <= erc_pkg::RST_COUNT;
    end
    else if (crc_error)
    begin
      crc_count_q <= crc_count_q + 16'h0001;
    end
  end

  // Overflow latch: a new roll in the read cycle is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovfl_q <= erc_pkg::RST_BYTE;
    end
    else
    begin
      if (rd_ovfl)
      begin
        ovfl_q <= erc_pkg::RST_BYTE;
      end
      if (lcv_roll && control_q[erc_pkg::CTL_OVFL_EN_BIT])
      begin
        ovfl_q[erc_pkg::OVFL_LCV_BIT] <= 1'b1;
      end
    end
  end

  assign lcv_overflow_pending = ovfl_q[erc_pkg::OVFL_LCV_BIT];

  // ************************************************************
  // Change detection on framer levels
  // ************************************************************
  // A level already high when reset ends reports one change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_sync_q      <= 1'b0;
      multiframe_sync_q <= 1'b0;
      crc_sync_q        <= 1'b0;
      all_ones_q        <= 1'b0;
    end
    else
    begin
      frame_sync_q      <= frame_sync;
      multiframe_sync_q <= multiframe_sync;
      crc_sync_q        <= crc_sync;
      all_ones_q        <= all_ones;
    end
  end

  // ************************************************************
  // Alternating pattern run detector
  // ************************************************************
  // A repeated bit restarts the run at one; a full run holds still
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_bit_q <= 1'b0;
      alt_run_q  <= 10'h000;
    end
    else if (rx_bit_valid)
    begin
      prev_bit_q <= rx_bit;
      if ((rx_bit != prev_bit_q) && (alt_run_q != 10'h000))
      begin
        if (alt_run_q != erc_pkg::AUX_RUN_BITS)
        begin
          alt_run_q <= alt_run_q + 10'h001;
        end
      end
      else
      begin
        alt_run_q <= 10'h001;
      end
    end
  end

  // Fires once, on the bit that completes the run
  assign alt_hit = rx_bit_valid && (rx_bit != prev_bit_q) &&
                   (alt_run_q == erc_pkg::AUX_RUN_BITS - 10'h001);

  // ************************************************************
  // Interrupt events
  // ************************************************************
  always_comb
  begin
    ev_zero = 8'h00;
    ev_one  = 8'h00;
    ev_zero[erc_pkg::W0_FRAME_SYNC] = frame_sync != frame_sync_q;
    ev_zero[erc_pkg::W0_MF_SYNC]    =
      multiframe_sync != multiframe_sync_q;
    ev_zero[erc_pkg::W0_CRC_SYNC]   = crc_sync != crc_sync_q;
    ev_zero[erc_pkg::W0_ALL_ONES]   = all_ones != all_ones_q;
    ev_zero[erc_pkg::W0_SIG_LOSS]   = signal_loss;
    ev_zero[erc_pkg::W0_DOUBLE_FAS] = double_errored_fas;
    ev_zero[erc_pkg::W0_MF_LOSS]    = multiframe_loss;
    ev_zero[erc_pkg::W0_SLIP]       = receive_slip;
    ev_one[erc_pkg::W1_FAS_BIT]     = fas_bit_error &&
                                      frame_sync;
    ev_one[erc_pkg::W1_LOCAL_CRC]   = crc_error;
    ev_one[erc_pkg::W1_FAR_EBIT]    = far_end_error_bit;
    ev_one[erc_pkg::W1_SLOT16]      = slot16_all_ones;
    ev_one[erc_pkg::W1_BIPOLAR]     = bipolar_violation;
    ev_one[erc_pkg::W1_PATTERN]     = test_pattern_error;
    ev_one[erc_pkg::W1_ALTERNATING] = alt_hit;
    ev_one[erc_pkg::W1_REMOTE]      = nfas_valid && nfas_bit3;
  end

  // ************************************************************
  // Interrupt status words, clear on read, set wins
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_zero_q <= erc_pkg::RST_BYTE;
    end
    else
    begin
      irq_zero_q <= (rd_irq_zero ? erc_pkg::RST_BYTE : irq_zero_q) |
                    (ev_zero & mask_zero_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_one_q <= erc_pkg::RST_BYTE;
    end
    else
    begin
      irq_one_q <= (rd_irq_one ? erc_pkg::RST_BYTE : irq_one_q) |
                   (ev_one & mask_one_q);
    end
  end

endmodule

`default_nettype wire

//--- sim/erc_rx_monitor_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Register port and overflow checks
// ************************************************************
module erc_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        bipolar_violation,
  input wire logic        excess_zero_seen,
  input wire logic        lcv_overflow_pending
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property
    (pready |-> psel && penable && $past(psel && penable))
    else $error("ready outside an access");
  a_err_align: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_data_idle: assert property (!pready || pwrite |-> prdata == 32'h0)
    else $error("read data outside read completion");
  a_map_lcv: assert property (
    pready && (paddr == 8'h58 || paddr == 8'h5C) |-> !pslverr)
    else $error("violation counter not mapped");
  a_map_crc: assert property (
    pready && (paddr == 8'h60 || paddr == 8'h64) |-> !pslverr)
    else $error("crc counter not mapped");
  a_gap_err: assert property (pready && paddr == 8'h68 |-> pslverr)
    else $error("unused index answered");
  a_ovfl_cause: assert property (
    $rose(lcv_overflow_pending)
    |-> $past(bipolar_violation || excess_zero_seen))
    else $error("overflow without a counted violation");
endmodule

bind erc_rx_monitor erc_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bipolar_violation(bipolar_violation),
  .excess_zero_seen(excess_zero_seen),
  .lcv_overflow_pending(lcv_overflow_pending));
`default_nettype wire

//--- sim/erc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Host side bus master
// ************************************************************
module erc_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic tmo = 1'b0;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    rd = 32'h0;
    er = 1'b1;
    tmo = 1'b1;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && tmo; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
      begin
        rd = prdata;
        er = pslverr;
        tmo = 1'b0;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~wd;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- sim/erc_rx_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
module erc_rx_monitor_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pend;
  logic [16:0] ev = 17'h00000;
  logic        rxb = 1'b0;
  logic        rxv = 1'b0;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          checked = 0;
  int          i;
  // Each row pulses inputs whose flags sit at the same bit positions
  logic [15:0] rows [15] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
    16'h0800, 16'h0400, 16'h0200, 16'h0100,
    16'h0080, 16'h0040, 16'h0020, 16'h0010,
    16'h0008, 16'h0004, 16'h0001};
  always #5 pclk = ~pclk;
  erc_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  erc_rx_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bipolar_violation(ev[3]), .excess_zero_seen(ev[16]),
    .crc_error(ev[6]), .frame_sync(ev[15]), .multiframe_sync(ev[14]),
    .crc_sync(ev[13]), .all_ones(ev[12]), .signal_loss(ev[11]),
    .double_errored_fas(ev[10]), .multiframe_loss(ev[9]),
    .receive_slip(ev[8]), .fas_bit_error(ev[7]),
    .far_end_error_bit(ev[5]), .slot16_all_ones(ev[4]),
    .test_pattern_error(ev[2]), .rx_bit(rxb), .rx_bit_valid(rxv),
    .nfas_valid(ev[0]), .nfas_bit3(ev[0]), .lcv_overflow_pending(pend));
  task chk(input logic [32:0] seen, input logic [32:0] exp,
    input string nm);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    host.xfer(w, a, {24'h0, d}, rd, er);
    if (host.tmo)
    begin
      err_count++;
      give_verdict;
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] exp, input logic ee,
    input string nm);
    bus(1'b0, a, 8'h00);
    chk({er, rd}, {ee, 24'h0, exp}, nm);
  endtask
  task pulse(input logic [16:0] p, input int n);
    ev <= ev ^ p;
    repeat (n) @(posedge pclk);
    ev <= ev & 17'h0F000;
  endtask
  task alt(input int n);
    repeat (n)
    begin
      rxb <= ~rxb;
      rxv <= 1'b1;
      @(posedge pclk);
    end
    rxv <= 1'b0;
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 7; i++)
      rdc(8'h58 + 8'(4 * i), 8'h00, i == 4, "reset map");
    pulse(17'h00100, 1);
    rdc(8'h6C, 8'h00, 1'b0, "masked slip");
    $display("reset and mask test done");
    bus(1'b1, 8'h84, 8'hFF);
    bus(1'b1, 8'h88, 8'hFF);
    for (i = 0; i < 15; i++)
    begin
      pulse({1'b0, rows[i]}, 1);
      rdc(8'h6C, rows[i][15:8], 1'b0, "word zero");
      rdc(8'h70, rows[i][7:0], 1'b0, "word one");
    end
    pulse(17'h08000, 1);
    rdc(8'h6C, 8'h80, 1'b0, "sync lost");
    pulse(17'h00080, 1);
    rdc(8'h70, 8'h00, 1'b0, "fas out of sync");
    $display("event table test done");
    rdc(8'h64, 8'h01, 1'b0, "crc low");
    rdc(8'h60, 8'h00, 1'b0, "crc high");
    pulse(17'h10000, 3);
    rdc(8'h5C, 8'h01, 1'b0, "zeros ignored");
    rdc(8'h70, 8'h00, 1'b0, "zeros no flag");
    bus(1'b1, 8'h80, 8'h03);
    pulse(17'h10000, 2);
    rdc(8'h5C, 8'h03, 1'b0, "zeros counted");
    pulse(17'h00008, 253);
    repeat (2) @(posedge pclk);
    chk({32'h0, pend}, 33'h1, "overflow pending");
    bus(1'b1, 8'h5C, 8'h55);
    rdc(8'h5C, 8'h00, 1'b0, "lcv low");
    rdc(8'h58, 8'h01, 1'b0, "lcv high");
    rdc(8'h70, 8'h08, 1'b0, "bipolar flag");
    rdc(8'h8C, 8'h08, 1'b0, "overflow status");
    chk({32'h0, pend}, 33'h0, "overflow cleared");
    $display("counter test done");
    rxv <= 1'b1;
    repeat (2) @(posedge pclk);
    rxv <= 1'b0;
    @(posedge pclk);
    alt(510);
    rdc(8'h70, 8'h00, 1'b0, "pattern short");
    alt(1);
    rdc(8'h70, 8'h02, 1'b0, "pattern done");
    alt(3);
    rdc(8'h70, 8'h00, 1'b0, "pattern no refire");
    rdc(8'h59, 8'h00, 1'b1, "misaligned");
    $display("pattern and refusal test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(8'h58, 8'h00, 1'b0, "reset lcv high");
    rdc(8'h64, 8'h00, 1'b0, "reset crc low");
    pulse(17'h00008, 1);
    rdc(8'h70, 8'h00, 1'b0, "reset masks");
    chk({32'h0, pend}, 33'h0, "reset pending");
    $display("mid-run reset test done");
    give_verdict;
  end
endmodule
`default_nettype wire
